// >>> src/ee_memory_access_regs.sv
// Special function registers that steer data and program memory access
`timescale 1ns/1ns
module ee_memory_access_regs (
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   input  wire ee_access_pkg::sfr_req_t   sfr_req,
   output logic [7:0]                     sfr_rdata,
   output ee_access_pkg::mem_req_t        mem_req,
   input  wire logic [13:0]               mem_rd_data,
   input  wire logic                      mem_wr_done,
   input  wire logic                      master_clear_input_n,
   input  wire logic                      watchdog_timeout
);
   logic [7:0] addr_low_reg,  addr_low_next;
   logic [3:0] addr_high_reg, addr_high_next;
   logic [7:0] data_low_reg,  data_low_next;
   logic [5:0] data_high_reg, data_high_next;
   logic       space_reg,     space_next;
   logic       abort_reg,     abort_next;
   logic       allow_reg,     allow_next;
   logic       wr_reg,        wr_next;
   logic       rd_reg,        rd_next;
   logic [7:0] rdata_reg,     rdata_next;
   logic       clear_level;
   logic       hold;
   logic       ctl_wr;

   pin_sync3 #(
      .IDLE      (ee_access_pkg::PIN_IDLE)
   ) pin_sync3_i (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .pin_in    (master_clear_input_n),
      .level_out (clear_level)
   );

   assign hold   = !clear_level || watchdog_timeout;
   assign ctl_wr = sfr_req.wr && sfr_req.sel == ee_access_pkg::SEL_CONTROL;

   always_comb begin
      addr_low_next  = addr_low_reg;
      addr_high_next = addr_high_reg;
      data_low_next  = data_low_reg;
      data_high_next = data_high_reg;
      space_next     = space_reg;
      abort_next     = abort_reg;
      allow_next     = allow_reg;
      wr_next        = wr_reg;
      rd_next        = rd_reg;
      if (sfr_req.wr) begin
         case (sfr_req.sel)
            ee_access_pkg::SEL_ADDR_LOW: begin
               addr_low_next = sfr_req.wdata;
            end
            ee_access_pkg::SEL_ADDR_HIGH: begin
               addr_high_next = sfr_req.wdata[3:0];
            end
            ee_access_pkg::SEL_DATA_LOW: begin
               data_low_next = sfr_req.wdata;
            end
            ee_access_pkg::SEL_DATA_HIGH: begin
               data_high_next = sfr_req.wdata[5:0];
            end
            ee_access_pkg::SEL_CONTROL: begin
               space_next = sfr_req.wdata[ee_access_pkg::CTL_SPACE_BIT];
               abort_next = sfr_req.wdata[ee_access_pkg::CTL_ABORT_BIT];
               allow_next = sfr_req.wdata[ee_access_pkg::CTL_ALLOW_BIT];
            end
            default: begin
            end
         endcase
      end
      if (rd_reg) begin
         rd_next = 1'b0;
      end
      if (wr_reg && mem_wr_done) begin
         wr_next = 1'b0;
      end
      if (ctl_wr && sfr_req.wdata[ee_access_pkg::CTL_RD_BIT]) begin
         rd_next = 1'b1;
      end
      // Writes ignored in program space or without permission
      if (ctl_wr && sfr_req.wdata[ee_access_pkg::CTL_WR_BIT] &&
          allow_reg && !space_reg) begin
         wr_next = 1'b1;
      end
      // capture fetched word into data registers
      if (rd_reg) begin
         data_low_next = mem_rd_data[7:0];
         if (space_reg) begin
            data_high_next = mem_rd_data[13:8];
         end
      end
      // abort flag set wins over software clear
      if (hold) begin
         rd_next    = 1'b0;
         wr_next    = 1'b0;
         allow_next = 1'b0;
         space_next = 1'b0;
         if (wr_reg) begin
            abort_next = 1'b1;
         end
      end
   end

   always_comb begin
      case (sfr_req.sel)
         ee_access_pkg::SEL_ADDR_LOW:  rdata_next = addr_low_reg;
         ee_access_pkg::SEL_ADDR_HIGH: rdata_next = {4'h0, addr_high_reg};
         ee_access_pkg::SEL_DATA_LOW:  rdata_next = data_low_reg;
         ee_access_pkg::SEL_DATA_HIGH: rdata_next = {2'h0, data_high_reg};
         ee_access_pkg::SEL_CONTROL: begin
            rdata_next = {space_reg, 3'h0, abort_reg, allow_reg,
                          wr_reg, rd_reg};
         end
         default: rdata_next = ee_access_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_low_reg  <= ee_access_pkg::REG_RESET;
         addr_high_reg <= ee_access_pkg::REG_RESET[3:0];
         data_low_reg  <= ee_access_pkg::REG_RESET;
         data_high_reg <= ee_access_pkg::REG_RESET[5:0];
         space_reg     <= 1'b0;
         abort_reg     <= 1'b0;
         allow_reg     <= 1'b0;
         wr_reg        <= 1'b0;
         rd_reg        <= 1'b0;
         rdata_reg     <= ee_access_pkg::REG_RESET;
      end else begin
         addr_low_reg  <= addr_low_next;
         addr_high_reg <= addr_high_next;
         data_low_reg  <= data_low_next;
         data_high_reg <= data_high_next;
         space_reg     <= space_next;
         abort_reg     <= abort_next;
         allow_reg     <= allow_next;
         wr_reg        <= wr_next;
         rd_reg        <= rd_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;

   // program space address joins high and low; data space address is the low byte with high bits zero
   always_comb begin
      mem_req.rd    = rd_reg;
      mem_req.wr    = wr_reg;
      mem_req.space = space_reg;
      mem_req.addr  = {space_reg ? addr_high_reg : 4'h0, addr_low_reg};
      mem_req.wdata = data_low_reg;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_rd_self_clear: assert property (
      rd_reg && !(ctl_wr && sfr_req.wdata[ee_access_pkg::CTL_RD_BIT])
      |=> !rd_reg) else $error("read trigger did not clear");
   a_wr_holds_busy: assert property (
      wr_reg && !mem_wr_done && !hold |=> wr_reg)
      else $error("write trigger dropped before completion");
   a_wr_done_clear: assert property (
      wr_reg && mem_wr_done |=> !wr_reg)
      else $error("write trigger stuck after completion");
   a_abort_on_reset: assert property (
      wr_reg && hold |=> abort_reg && !wr_reg)
      else $error("interrupted write not flagged");
   a_prog_word_capture: assert property (
      rd_reg && space_reg && !hold
      |=> data_high_reg == $past(mem_rd_data[13:8]))
      else $error("upper word bits not captured");
   a_data_high_zero: assert property (
      sfr_req.sel == ee_access_pkg::SEL_DATA_HIGH
      |=> sfr_rdata == {2'h0, $past(data_high_reg)})
      else $error("high data upper bits not zero");
   a_addr_high_zero: assert property (
      sfr_req.sel == ee_access_pkg::SEL_ADDR_HIGH
      |=> sfr_rdata == {4'h0, $past(addr_high_reg)})
      else $error("high address upper bits not zero");
   a_addr_low_write: assert property (
      sfr_req.wr && sfr_req.sel == ee_access_pkg::SEL_ADDR_LOW
      |=> mem_req.addr[7:0] == $past(sfr_req.wdata))
      else $error("low address not stored");
   a_prog_addr_join: assert property (
      space_reg |-> mem_req.addr[11:8] == addr_high_reg)
      else $error("program address high bits wrong");
   a_space_blocks_wr: assert property (
      !wr_reg && space_reg |=> !wr_reg)
      else $error("write started in program space");

   c_data_read:  cover property (rd_reg && !space_reg);
   c_prog_read:  cover property (rd_reg && space_reg);
   c_write_done: cover property (wr_reg && mem_wr_done);
   c_abort:      cover property (wr_reg && hold);
endmodule

// >>> pkg/ee_access_pkg.sv
// Constants and carrier types for the memory access register block
package ee_access_pkg;
   localparam logic [2:0] SEL_ADDR_LOW   = 3'h0;
   localparam logic [2:0] SEL_ADDR_HIGH  = 3'h1;
   localparam logic [2:0] SEL_DATA_LOW   = 3'h2;
   localparam logic [2:0] SEL_DATA_HIGH  = 3'h3;
   localparam logic [2:0] SEL_CONTROL    = 3'h4;
   localparam int         CTL_SPACE_BIT  = 7;
   localparam int         CTL_ABORT_BIT  = 3;
   localparam int         CTL_ALLOW_BIT  = 2;
   localparam int         CTL_WR_BIT     = 1;
   localparam int         CTL_RD_BIT     = 0;
   localparam logic [7:0] ADDR_HIGH_MASK = 8'h0f;
   localparam logic [7:0] DATA_HIGH_MASK = 8'h3f;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;
   localparam logic       PIN_IDLE       = 1'h1;

   typedef struct packed {
      logic       wr;
      logic [2:0] sel;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        space;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;
endpackage

// >>> src/pin_sync3.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ns
module pin_sync3 #(
   parameter logic IDLE = 1'h1
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       level_reg;
   logic       level_next;

   always_comb begin
      stage_next = {stage_reg[1:0], pin_in};
      level_next = level_reg;
      // First stage feeds only the second
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage_reg <= {3{IDLE}};
         level_reg <= IDLE;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end

   assign level_out = level_reg;
endmodule

// >>> verification/tb_ee_memory_access_regs.sv
// Self-checking bench for the memory access register block
`timescale 1ns/1ns
module tb_ee_memory_access_regs;
   logic                    core_clk;
   logic                    sys_rst;
   ee_access_pkg::sfr_req_t sfr_req;
   logic [7:0]              sfr_rdata;
   ee_access_pkg::mem_req_t mem_req;
   logic [13:0]             mem_rd_data;
   logic                    mem_wr_done;
   logic                    master_clear_input_n;
   logic                    watchdog_timeout;
   int                      n_errors;
   int                      tests_run;
   logic [7:0]              v;
   logic [7:0]              lo;
   logic [7:0]              hi;
   logic [2:0]              s;
   logic [13:0]             word;
   logic                    rd_seen;

   ee_memory_access_regs ee_memory_access_regs_i (
      .core_clk             (core_clk),
      .sys_rst              (sys_rst),
      .sfr_req              (sfr_req),
      .sfr_rdata            (sfr_rdata),
      .mem_req              (mem_req),
      .mem_rd_data          (mem_rd_data),
      .mem_wr_done          (mem_wr_done),
      .master_clear_input_n (master_clear_input_n),
      .watchdog_timeout     (watchdog_timeout)
   );

   initial begin
      forever #50 core_clk = ~core_clk;
   end

   task stop_test;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs move 10 ns after the edge, clear of the sampling instant
   task cyc(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #10;
      end
   endtask

   task wr_reg(input logic [2:0] sl, input logic [7:0] d);
      sfr_req.sel = sl;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      cyc(1);
      rd_seen = mem_req.rd;
      sfr_req.wr = 1'b0;
      // Idle edge keeps back-to-back strobes apart
      cyc(1);
   endtask

   // Read data follows the select by one edge
   task rd_reg(input logic [2:0] sl, output logic [7:0] d);
      sfr_req.sel = sl;
      cyc(1);
      d = sfr_rdata;
   endtask

   function automatic logic [7:0] mask_of(input logic [2:0] sl);
      case (sl)
         ee_access_pkg::SEL_ADDR_LOW:  return 8'hff;
         ee_access_pkg::SEL_DATA_LOW:  return 8'hff;
         ee_access_pkg::SEL_ADDR_HIGH: return ee_access_pkg::ADDR_HIGH_MASK;
         ee_access_pkg::SEL_DATA_HIGH: return ee_access_pkg::DATA_HIGH_MASK;
         default:                      return 8'h00;
      endcase
   endfunction

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      sfr_req = '0;
      mem_rd_data = 14'h0000;
      mem_wr_done = 1'b0;
      master_clear_input_n = 1'b1;
      watchdog_timeout = 1'b0;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(71));
      repeat (16) @(posedge core_clk);
      #10;
      sys_rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_reg(3'(i), v);
         chk(v, 8'h00);
      end
      // First two passes hit the unimplemented high bits with all ones
      for (int i = 0; i < 14; i++) begin
         s = (i < 2) ? 3'(2 * i + 1) : 3'($urandom_range(0, 7));
         if (s == ee_access_pkg::SEL_CONTROL) s = 3'h2;
         v = (i < 2) ? 8'hff : 8'($urandom);
         wr_reg(s, v);
         rd_reg(s, lo);
         chk(lo, v & mask_of(s));
      end
      lo = 8'($urandom);
      hi = 8'($urandom);
      word = 14'($urandom);
      mem_rd_data = word;
      wr_reg(ee_access_pkg::SEL_ADDR_LOW, lo);
      wr_reg(ee_access_pkg::SEL_ADDR_HIGH, hi);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h80);
      chk(mem_req.addr, {hi[3:0], lo});
      chk(mem_req.space, 1'b1);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h81);
      chk(rd_seen, 1'b1);
      cyc(1);
      chk(mem_req.rd, 1'b0);
      rd_reg(ee_access_pkg::SEL_CONTROL, v);
      chk(v, 8'h80);
      rd_reg(ee_access_pkg::SEL_DATA_HIGH, v);
      chk(v, {2'h0, word[13:8]});
      chk(mem_req.wdata, word[7:0]);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h00);
      chk(mem_req.addr, {4'h0, lo});
      chk(mem_req.space, 1'b0);
      // Data space read loads the low byte only
      mem_rd_data = ~word;
      hi = ~word[7:0];
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h01);
      chk(rd_seen, 1'b1);
      rd_reg(ee_access_pkg::SEL_DATA_LOW, v);
      chk(v, hi);
      rd_reg(ee_access_pkg::SEL_DATA_HIGH, v);
      chk(v, {2'h0, word[13:8]});
      // Refused: trigger without write permission
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h02);
      chk(mem_req.wr, 1'b0);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h04);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h06);
      wr_reg(ee_access_pkg::SEL_CONTROL, 8'h04);
      chk(mem_req.wr, 1'b1);
      mem_wr_done = 1'b1;
      cyc(1);
      mem_wr_done = 1'b0;
      chk(mem_req.wr, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wr_reg(ee_access_pkg::SEL_CONTROL, 8'h04);
         wr_reg(ee_access_pkg::SEL_CONTROL, 8'h06);
         if (k == 0) begin
            watchdog_timeout = 1'b1;
            cyc(1);
            watchdog_timeout = 1'b0;
         end else begin
            master_clear_input_n = 1'b0;
            cyc(8);
            master_clear_input_n = 1'b1;
            cyc(6);
         end
         rd_reg(ee_access_pkg::SEL_CONTROL, v);
         chk(v, 8'h08);
      end
      // Second reset in mid-run must clear loaded registers
      sys_rst = 1'b1;
      cyc(2);
      sys_rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_reg(3'(i), v);
         chk(v, 8'h00);
      end
      stop_test;
   end

   // Whole sequence needs well under 300 cycles
   initial begin
      repeat (3000) @(posedge core_clk);
      n_errors++;
      stop_test;
   end
endmodule
